/* core/ecr_cfg.svh */
/*
 * constants of the extension control register bank: bit positions,
 * implemented-bit mask, reset value and control register numbers.
 * assumes it is included by bare name from the access check and bank modules.
 */
`ifndef ECR_CFG_SVH
`define ECR_CFG_SVH

// ==================================================
// extension control register bit positions
`define ECR_V86_EXT 0
`define ECR_PROT_VINT 1
`define ECR_TS_RESTRICT 2
`define ECR_IO_BP 3
`define ECR_LARGE_PAGE 4
`define ECR_WIDE_PHYS 5
`define ECR_MCHK 6
`define ECR_GLOBAL_PAGE 7
`define ECR_PMC_USER 8
`define ECR_LEGACY_VEC 9
`define ECR_VEC_FP_EXC 10
`define ECR_SEG_BASE 16
`define ECR_EXT_STATE 18

// ==================================================
// masks and reset values
`define ECR_IMPL_MASK 64'h0000_0000_0005_07ff
`define ECR_RESET 64'h0000_0000_0000_0000
`define ECR_HI_ZERO 32'h0000_0000
`define CR_RESET 64'h0000_0000_0000_0000

// ==================================================
// control register numbers
`define CRN_ELSEWHERE_A 4'h0
`define CRN_FAULT_ADDR 4'h2
`define CRN_TABLE_BASE 4'h3
`define CRN_EXT_CTRL 4'h4
`define CRN_ELSEWHERE_B 4'h8

// ==================================================
// current privilege level with full privilege
`define CPL_KERNEL 2'h0
// debug register indices
`define DBG_ALIAS_A 3'h4
`define DBG_ALIAS_B 3'h5
`define DBG_STATUS 3'h6
`define DBG_CONTROL 3'h7

`endif

/* core/ecr_pkg.sv */
/*
 * types of the extension control register bank.
 * assumes ecr_cfg.svh is on the include path.
 */
`default_nettype none
package ecr_pkg;
    // fault raised by an access or a gated operation
    typedef enum logic [2:0] {FLT_NONE, FLT_INVALID_OPCODE, FLT_PROTECTION, FLT_SIMD_FP, FLT_MACHINE_CHECK} fault_t;
    // which register an access reaches
    typedef enum logic [2:0] {SEL_ELSEWHERE, SEL_FAULT_ADDR, SEL_TABLE_BASE, SEL_EXT_CTRL, SEL_RESERVED} cr_sel_t;
    // operations whose legality or behaviour depends on the register
    typedef enum logic [3:0] {OP_READ_TS, OP_READ_PMC, OP_DEBUG_A, OP_DEBUG_B, OP_SEG_BASE, OP_EXT_CTRL,
        OP_EXT_SAVE, OP_LEGACY_VEC, OP_VEC_FP_EXC, OP_INT_FLAG, OP_SW_INT} op_kind_t;
    // move to or from a control register
    typedef struct packed {
        logic write;
        logic [3:0] crnum;
        logic [63:0] wdata;
    } acc_req_t;
    // operation check request
    typedef struct packed {
        op_kind_t kind;
        logic [1:0] current_priv_level;
    } op_req_t;
    // operation check answer
    typedef struct packed {
        fault_t fault;
        logic [2:0] debug_sel;
        logic virt_int;
        logic redirect_bitmap;
    } op_rsp_t;
    // machine check error report
    typedef struct packed {
        logic [7:0] bank;
        logic uncorrectable;
    } mc_err_t;
    // page translation configuration
    typedef struct packed {
        logic wide_entries;
        logic large_page_ok;
        logic large_is_2m;
        logic global_en;
    } page_cfg_t;
endpackage
`default_nettype wire

/* core/ecr_access_check.sv */
/*
 * classifies a control register access and finds its fault.
 * assumes a combinational caller on the core clock.
 */
`include "ecr_cfg.svh"
`default_nettype none
module ecr_access_check (
    // access
    input wire ecr_pkg::acc_req_t req,
    input wire logic long_mode,
    // classification
    output ecr_pkg::cr_sel_t sel,
    output ecr_pkg::fault_t fault
);
    import ecr_pkg::*;

    // ==================================================
    // register selection
    always_comb begin
        if (req.crnum == `CRN_FAULT_ADDR) begin
            sel = SEL_FAULT_ADDR;
        end else if (req.crnum == `CRN_TABLE_BASE) begin
            sel = SEL_TABLE_BASE;
        end else if (req.crnum == `CRN_EXT_CTRL) begin
            sel = SEL_EXT_CTRL;
        end else if (req.crnum == `CRN_ELSEWHERE_A || req.crnum == `CRN_ELSEWHERE_B) begin
            sel = SEL_ELSEWHERE;  // handled by another bank
        end else begin
            sel = SEL_RESERVED;  // numbers 1, 5..7, 9..15
        end
    end

    // ==================================================
    // fault of the access
    always_comb begin
        if (sel == SEL_RESERVED) begin
            fault = FLT_INVALID_OPCODE;
        end else if (sel == SEL_EXT_CTRL && req.write && long_mode && req.wdata[63:32] != `ECR_HI_ZERO) begin
            fault = FLT_PROTECTION;
        end else begin
            fault = FLT_NONE;
        end
    end
endmodule
`default_nettype wire

/* core/ecr_bank.sv */
/*
 * extension control register bank with fault address and table base
 * registers, operation gating and machine check recording.
 * assumes requests come from logic on CLK, one per cycle at most.
 */
`include "ecr_cfg.svh"
`default_nettype none
module ecr_bank #(
    parameter int MC_BANKS = 4
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // processor mode
    input wire logic LONG_MODE,
    input wire logic V86_MODE,
    // control register access
    input wire logic ACC_VALID,
    input wire ecr_pkg::acc_req_t ACC_REQ,
    output logic RSP_VALID,
    output logic [63:0] RSP_RDATA,
    output ecr_pkg::fault_t RSP_FAULT,
    output logic RSP_CLAIMED,
    // operation gating
    input wire logic OP_VALID,
    input wire ecr_pkg::op_req_t OP_REQ,
    output logic OP_DONE,
    output ecr_pkg::op_rsp_t OP_RSP,
    // machine check
    input wire logic MC_ERR_VALID,
    input wire ecr_pkg::mc_err_t MC_ERR,
    input wire logic [MC_BANKS-1:0] MC_BANK_ENABLE,
    input wire logic [MC_BANKS-1:0] MC_STATUS_CLR,
    output logic [MC_BANKS-1:0] MC_STATUS,
    output logic MC_FAULT,
    // page translation
    output ecr_pkg::page_cfg_t PAGE_CFG,
    output logic [63:0] TABLE_BASE,
    output logic TLB_FLUSH,
    output logic TLB_KEEP_GLOBAL,
    // feature lines
    output logic [63:0] EXT_CTRL
);
    import ecr_pkg::*;

    logic rst_meta;  // first reset stage
    logic rst_n;  // released reset
    logic [63:0] ecr;  // extension control register
    logic [63:0] fault_addr;  // fault address register
    logic [63:0] table_base;  // table base register
    cr_sel_t sel;  // access target
    fault_t acc_fault;  // access fault
    logic acc_ok;  // access goes ahead
    logic [63:0] next_wide;  // write data as seen in the mode
    logic [63:0] next_rdata;  // read data before the register

    // ==================================================
    // reset release
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ==================================================
    // access decode
    ecr_access_check u_check (
        .req(ACC_REQ),
        .long_mode(LONG_MODE),
        .sel(sel),
        .fault(acc_fault)
    );

    assign acc_ok = ACC_VALID && acc_fault == FLT_NONE;
    // legacy writes take the low half and zero the upper half
    assign next_wide = LONG_MODE ? ACC_REQ.wdata : {`ECR_HI_ZERO, ACC_REQ.wdata[31:0]};

    // read data by target
    always_comb begin
        if (sel == SEL_EXT_CTRL) begin
            next_rdata = ecr;
        end else if (sel == SEL_FAULT_ADDR) begin
            next_rdata = fault_addr;
        end else if (sel == SEL_TABLE_BASE) begin
            next_rdata = table_base;
        end else begin
            next_rdata = 64'h0;
        end
        if (!LONG_MODE) begin
            next_rdata[63:32] = `ECR_HI_ZERO;
        end
    end

    // ==================================================
    // extension control register
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ecr <= `ECR_RESET;
        end else if (acc_ok && ACC_REQ.write && sel == SEL_EXT_CTRL) begin
            // undefined bits stay zero; legacy writes keep the upper half
            ecr <= {ecr[63:32], next_wide[31:0]} & `ECR_IMPL_MASK;
        end
    end

    // ==================================================
    // fault address register, fully writable
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            fault_addr <= `CR_RESET;
        end else if (acc_ok && ACC_REQ.write && sel == SEL_FAULT_ADDR) begin
            fault_addr <= next_wide;
        end
    end

    // ==================================================
    // table base register and translation flush
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            table_base <= `CR_RESET;
            TLB_FLUSH <= 1'b0;
        end else begin
            TLB_FLUSH <= 1'b0;
            if (acc_ok && ACC_REQ.write && sel == SEL_TABLE_BASE) begin
                table_base <= next_wide;
                TLB_FLUSH <= 1'b1;
            end
        end
    end

    // ==================================================
    // access answer, one cycle after the request
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RSP_VALID <= 1'b0;
            RSP_RDATA <= 64'h0;
            RSP_FAULT <= FLT_NONE;
            RSP_CLAIMED <= 1'b0;
        end else begin
            RSP_VALID <= ACC_VALID;
            RSP_FAULT <= ACC_VALID ? acc_fault : FLT_NONE;
            RSP_CLAIMED <= ACC_VALID && sel != SEL_ELSEWHERE;
            // read data only for a good read
            RSP_RDATA <= (acc_ok && !ACC_REQ.write) ? next_rdata : 64'h0;
        end
    end

    // ==================================================
    // derived configuration outputs
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PAGE_CFG <= '0;
            TLB_KEEP_GLOBAL <= 1'b0;
            TABLE_BASE <= `CR_RESET;
            EXT_CTRL <= `ECR_RESET;
        end else begin
            PAGE_CFG.wide_entries <= ecr[`ECR_WIDE_PHYS];
            PAGE_CFG.large_page_ok <= ecr[`ECR_WIDE_PHYS] | ecr[`ECR_LARGE_PAGE];
            PAGE_CFG.large_is_2m <= ecr[`ECR_WIDE_PHYS];
            PAGE_CFG.global_en <= ecr[`ECR_GLOBAL_PAGE];
            TLB_KEEP_GLOBAL <= ecr[`ECR_GLOBAL_PAGE];
            TABLE_BASE <= table_base;
            EXT_CTRL <= ecr;
        end
    end

    // ==================================================
    // operation gating, answered one cycle later
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            OP_DONE <= 1'b0;
            OP_RSP <= '0;
        end else begin
            OP_DONE <= OP_VALID;
            OP_RSP.fault <= FLT_NONE;
            OP_RSP.debug_sel <= 3'h0;
            OP_RSP.virt_int <= 1'b0;
            OP_RSP.redirect_bitmap <= 1'b0;
            if (OP_VALID) begin
                case (OP_REQ.kind)
                    OP_READ_TS: begin
                        if (ecr[`ECR_TS_RESTRICT] && OP_REQ.current_priv_level != `CPL_KERNEL) begin
                            OP_RSP.fault <= FLT_PROTECTION;
                        end
                    end
                    OP_READ_PMC: begin
                        if (!ecr[`ECR_PMC_USER] && OP_REQ.current_priv_level != `CPL_KERNEL) begin
                            OP_RSP.fault <= FLT_PROTECTION;
                        end
                    end
                    OP_DEBUG_A: begin
                        // reserved when breakpoints are on, aliased otherwise
                        OP_RSP.fault <= ecr[`ECR_IO_BP] ? FLT_INVALID_OPCODE : FLT_NONE;
                        OP_RSP.debug_sel <= ecr[`ECR_IO_BP] ? `DBG_ALIAS_A : `DBG_STATUS;
                    end
                    OP_DEBUG_B: begin
                        OP_RSP.fault <= ecr[`ECR_IO_BP] ? FLT_INVALID_OPCODE : FLT_NONE;
                        OP_RSP.debug_sel <= ecr[`ECR_IO_BP] ? `DBG_ALIAS_B : `DBG_CONTROL;
                    end
                    OP_SEG_BASE: begin
                        if (!ecr[`ECR_SEG_BASE] || !LONG_MODE) begin
                            OP_RSP.fault <= FLT_INVALID_OPCODE;
                        end
                    end
                    OP_EXT_CTRL, OP_EXT_SAVE: begin
                        if (!ecr[`ECR_EXT_STATE]) begin
                            OP_RSP.fault <= FLT_INVALID_OPCODE;
                        end
                    end
                    OP_LEGACY_VEC: begin
                        if (!ecr[`ECR_LEGACY_VEC]) begin
                            OP_RSP.fault <= FLT_INVALID_OPCODE;
                        end
                    end
                    OP_VEC_FP_EXC: begin
                        OP_RSP.fault <= ecr[`ECR_VEC_FP_EXC] ? FLT_SIMD_FP : FLT_INVALID_OPCODE;
                    end
                    OP_INT_FLAG: begin
                        // flag virtualised in v86 or protected mode
                        OP_RSP.virt_int <= V86_MODE ? ecr[`ECR_V86_EXT] : ecr[`ECR_PROT_VINT];
                    end
                    OP_SW_INT: begin
                        // bitmap only in v86 mode, never for protected virtual ints
                        OP_RSP.redirect_bitmap <= V86_MODE && ecr[`ECR_V86_EXT];
                    end
                    default: begin
                        OP_RSP.fault <= FLT_NONE;
                    end
                endcase
            end
        end
    end

    // ==================================================
    // machine check recording and fault
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            MC_STATUS <= '0;
            MC_FAULT <= 1'b0;
        end else begin
            MC_FAULT <= 1'b0;
            for (int i = 0; i < MC_BANKS; i++) begin
                if (MC_ERR_VALID && MC_ERR.bank == 8'(i) && MC_BANK_ENABLE[i]) begin
                    MC_STATUS[i] <= 1'b1;  // set wins over clear
                    if (MC_ERR.uncorrectable && ecr[`ECR_MCHK]) begin
                        MC_FAULT <= 1'b1;
                    end
                end else if (MC_STATUS_CLR[i]) begin
                    MC_STATUS[i] <= 1'b0;
                end
            end
        end
    end

    // ==================================================
    // checks
    a_resp_timing: assert property (@(posedge CLK) disable iff (!rst_n)
        ACC_VALID |=> RSP_VALID) else $error("access not answered next cycle");
    a_reserved_num: assert property (@(posedge CLK) disable iff (!rst_n)
        ACC_VALID && (ACC_REQ.crnum == 4'h1 || ACC_REQ.crnum == 4'h6 || ACC_REQ.crnum == 4'hc)
        |=> RSP_FAULT == FLT_INVALID_OPCODE) else $error("reserved number not faulted");
    a_upper_gp: assert property (@(posedge CLK) disable iff (!rst_n)
        ACC_VALID && ACC_REQ.write && ACC_REQ.crnum == 4'h4 && LONG_MODE && ACC_REQ.wdata[63:32] != 32'h0
        |=> RSP_FAULT == FLT_PROTECTION && $stable(ecr)) else $error("upper write not refused");
    a_legacy_read: assert property (@(posedge CLK) disable iff (!rst_n)
        ACC_VALID && !ACC_REQ.write && ACC_REQ.crnum == 4'h4 && !LONG_MODE
        |=> RSP_RDATA == {32'h0, $past(ecr[31:0])}) else $error("legacy read wrong");
    a_ts_restrict: assert property (@(posedge CLK) disable iff (!rst_n)
        OP_VALID && OP_REQ.kind == OP_READ_TS && OP_REQ.current_priv_level != 2'h0
        |=> OP_RSP.fault == ($past(ecr[2]) ? FLT_PROTECTION : FLT_NONE)) else $error("timestamp gate wrong");
    a_pmc_gate: assert property (@(posedge CLK) disable iff (!rst_n)
        OP_VALID && OP_REQ.kind == OP_READ_PMC
        |=> (OP_RSP.fault == FLT_PROTECTION) == ($past(!ecr[8] && OP_REQ.current_priv_level != 2'h0)))
        else $error("counter gate wrong");
    a_debug_alias: assert property (@(posedge CLK) disable iff (!rst_n)
        OP_VALID && OP_REQ.kind == OP_DEBUG_B && !ecr[3]
        |=> OP_RSP.debug_sel == 3'h7 && OP_RSP.fault == FLT_NONE) else $error("alias not redirected");
    a_vec_fp: assert property (@(posedge CLK) disable iff (!rst_n)
        OP_VALID && OP_REQ.kind == OP_VEC_FP_EXC && !ecr[10]
        |=> OP_RSP.fault == FLT_INVALID_OPCODE) else $error("vector fault not converted");
    a_mc_fault: assert property (@(posedge CLK) disable iff (!rst_n)
        MC_FAULT |-> $past(MC_ERR_VALID && MC_ERR.uncorrectable && ecr[6])) else $error("spurious machine check");
    a_tlb_flush: assert property (@(posedge CLK) disable iff (!rst_n)
        ACC_VALID && ACC_REQ.write && ACC_REQ.crnum == 4'h3
        |=> TLB_FLUSH ##1 TABLE_BASE == $past(table_base)) else $error("rebase not flushed");
    a_ext_state: assert property (@(posedge CLK) disable iff (!rst_n)
        OP_VALID && OP_REQ.kind == OP_EXT_SAVE && ecr[18]
        |=> OP_RSP.fault == FLT_NONE) else $error("extended state refused");
endmodule
`default_nettype wire

/* test/tb.sv */
/*
 * self-checking bench of the extension control register bank.
 * assumes ecr_pkg is compiled first; no other model stands beside the block.
 */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ecr_pkg::*;
    // ==================================================
    // table row: an access when op is 0, an operation check otherwise
    typedef struct packed {
        logic op;
        logic lm;
        logic v86;
        logic wr;
        logic [3:0] crn;
        logic [63:0] wd;
        op_kind_t kind;
        logic [1:0] current_priv_level;
        fault_t ef;
        logic [63:0] ed;
    } row_t;
    // ==================================================
    // stimulus and observed signals
    logic clk, rst_n, long_mode, v86_mode, acc_valid, op_valid, mc_err_valid;
    logic rsp_valid, rsp_claimed, op_done, mc_fault, tlb_flush, tlb_keep_global;
    acc_req_t acc_req;
    op_req_t op_req;
    mc_err_t mc_err;
    logic [3:0] mc_bank_enable, mc_status_clr, mc_status;
    logic [63:0] rsp_rdata, table_base, ext_ctrl, got;
    fault_t rsp_fault, gf;
    op_rsp_t op_rsp, orsp;
    page_cfg_t page_cfg;
    logic gc, f;
    int errors, compares;
    row_t rows[$];
    row_t r;
    // page tests: large pages, both, wide only, global
    logic [63:0] pg[4] = '{64'h10, 64'h30, 64'h20, 64'h80};
    // ==================================================
    // block under test
    ecr_bank #(.MC_BANKS(4)) DUT (.CLK(clk), .RST_N(rst_n), .LONG_MODE(long_mode), .V86_MODE(v86_mode),
        .ACC_VALID(acc_valid), .ACC_REQ(acc_req), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
        .RSP_FAULT(rsp_fault), .RSP_CLAIMED(rsp_claimed), .OP_VALID(op_valid), .OP_REQ(op_req),
        .OP_DONE(op_done), .OP_RSP(op_rsp), .MC_ERR_VALID(mc_err_valid), .MC_ERR(mc_err),
        .MC_BANK_ENABLE(mc_bank_enable), .MC_STATUS_CLR(mc_status_clr), .MC_STATUS(mc_status),
        .MC_FAULT(mc_fault), .PAGE_CFG(page_cfg), .TABLE_BASE(table_base), .TLB_FLUSH(tlb_flush),
        .TLB_KEEP_GLOBAL(tlb_keep_global), .EXT_CTRL(ext_ctrl));
    // 25 MHz core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ==================================================
    // verdict and end of run
    task finish_test();
        if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // compare one value, report at once
    task check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one register access, answer captured when it stands
    task acc(input logic wr, input logic [3:0] crn, input logic [63:0] wd);
        int n;
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_req <= '{write: wr, crnum: crn, wdata: wd};
        @(posedge clk);
        acc_valid <= 1'b0;
        #1;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        // no answer counts as a mismatch
        if (rsp_valid !== 1'b1) begin
            errors++;
            finish_test();
        end
        got = rsp_rdata;
        gf = rsp_fault;
        gc = rsp_claimed;
    endtask
    // one operation check
    task opc(input op_kind_t k, input logic [1:0] current_priv_level);
        int n;
        @(posedge clk);
        op_valid <= 1'b1;
        op_req <= '{kind: k, current_priv_level: current_priv_level};
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        n = 0;
        while (op_done !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (op_done !== 1'b1) begin
            errors++;
            finish_test();
        end
        orsp = op_rsp;
    endtask
    // one error event; f gathers any fault pulse over three cycles
    task mc(input logic [7:0] b, input logic u);
        @(posedge clk);
        mc_err_valid <= 1'b1;
        mc_err <= '{bank: b, uncorrectable: u};
        @(posedge clk);
        mc_err_valid <= 1'b0;
        f = 1'b0;
        repeat (3) begin
            #1;
            f = f | mc_fault;
            @(posedge clk);
        end
        #1;
    endtask
    // row builders
    task a(input logic lm, input logic wr, input logic [3:0] crn, input logic [63:0] wd, input fault_t ef,
        input logic [63:0] ed);
        rows.push_back('{1'b0, lm, 1'b0, wr, crn, wd, OP_READ_TS, 2'h0, ef, ed});
    endtask
    task o(input logic v86, input logic lm, input op_kind_t k, input logic [1:0] current_priv_level, input fault_t ef,
        input logic [63:0] ed);
        rows.push_back('{1'b1, lm, v86, 1'b0, 4'h4, 64'h0, k, current_priv_level, ef, ed});
    endtask
    // ==================================================
    // main sequence
    initial begin
        {rst_n, long_mode, v86_mode, acc_valid, op_valid, mc_err_valid} = 6'h00;
        acc_req = '0;
        op_req = '0;
        mc_err = '0;
        mc_bank_enable = 4'h5;
        mc_status_clr = 4'h0;
        errors = 0;
        compares = 0;
        // every bit set, then refused upper half, then features one by one
        a(1, 0, 4, 64'h0, FLT_NONE, 64'h0);
        a(1, 1, 4, 64'h200, FLT_NONE, 64'h0); // legacy vectors before extended state
        a(1, 1, 4, 64'hf_ffff, FLT_NONE, 64'h0);
        a(1, 0, 4, 64'h0, FLT_NONE, 64'h5_07ff);
        a(1, 1, 4, 64'h1_0000_0000, FLT_PROTECTION, 64'h0);
        a(1, 0, 4, 64'h0, FLT_NONE, 64'h5_07ff);
        o(0, 1, OP_READ_TS, 3, FLT_PROTECTION, 0);
        o(0, 1, OP_READ_TS, 0, FLT_NONE, 0);
        o(0, 1, OP_READ_PMC, 3, FLT_NONE, 0);
        o(0, 1, OP_DEBUG_A, 0, FLT_INVALID_OPCODE, 4);
        o(0, 1, OP_DEBUG_B, 0, FLT_INVALID_OPCODE, 5);
        o(0, 1, OP_SEG_BASE, 3, FLT_NONE, 0);
        o(0, 0, OP_SEG_BASE, 3, FLT_INVALID_OPCODE, 0);
        o(0, 1, OP_EXT_CTRL, 0, FLT_NONE, 0);
        o(0, 1, OP_EXT_SAVE, 0, FLT_NONE, 0);
        o(0, 1, OP_LEGACY_VEC, 3, FLT_NONE, 0);
        o(0, 1, OP_VEC_FP_EXC, 3, FLT_SIMD_FP, 0);
        o(1, 1, OP_INT_FLAG, 3, FLT_NONE, 1);
        o(1, 1, OP_SW_INT, 3, FLT_NONE, 1);
        o(0, 1, OP_INT_FLAG, 3, FLT_NONE, 1);
        a(1, 1, 4, 64'h0, FLT_NONE, 64'h0);
        o(0, 1, OP_READ_TS, 3, FLT_NONE, 0);
        o(0, 1, OP_READ_PMC, 3, FLT_PROTECTION, 0);
        o(0, 1, OP_READ_PMC, 0, FLT_NONE, 0);
        o(0, 1, OP_DEBUG_A, 0, FLT_NONE, 6);
        o(0, 1, OP_DEBUG_B, 0, FLT_NONE, 7);
        o(0, 1, OP_SEG_BASE, 0, FLT_INVALID_OPCODE, 0);
        o(0, 1, OP_EXT_CTRL, 0, FLT_INVALID_OPCODE, 0);
        o(0, 1, OP_EXT_SAVE, 0, FLT_INVALID_OPCODE, 0);
        o(0, 1, OP_LEGACY_VEC, 0, FLT_INVALID_OPCODE, 0);
        o(0, 1, OP_VEC_FP_EXC, 0, FLT_INVALID_OPCODE, 0);
        o(1, 1, OP_INT_FLAG, 3, FLT_NONE, 0);
        o(1, 1, OP_SW_INT, 3, FLT_NONE, 0);
        a(1, 1, 4, 64'h2, FLT_NONE, 64'h0);
        o(1, 1, OP_INT_FLAG, 3, FLT_NONE, 0);
        o(0, 1, OP_INT_FLAG, 3, FLT_NONE, 1);
        o(1, 1, OP_SW_INT, 3, FLT_NONE, 0);
        // legacy mode shows and takes the low half only
        a(0, 1, 4, 64'hffff_ffff_0000_0041, FLT_NONE, 64'h0);
        a(0, 0, 4, 64'h0, FLT_NONE, 64'h41);
        a(1, 0, 4, 64'h0, FLT_NONE, 64'h41);
        a(1, 1, 2, 64'hfedc_ba98_7654_3210, FLT_NONE, 64'h0);
        a(1, 0, 2, 64'h0, FLT_NONE, 64'hfedc_ba98_7654_3210);
        a(0, 0, 2, 64'h0, FLT_NONE, 64'h7654_3210);
        // reset held 16 cycles, outputs quiet meanwhile
        repeat (16) @(posedge clk);
        check(ext_ctrl, 64'h0); // reset value
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge clk);
            long_mode <= r.lm;
            v86_mode <= r.v86;
            if (!r.op) begin
                acc(r.wr, r.crn, r.wd);
                check(64'(gf), 64'(r.ef)); // access fault
                if (!r.wr)
                    check(got, r.ed); // read data
            end else begin
                opc(r.kind, r.current_priv_level);
                check(64'(orsp.fault), 64'(r.ef)); // gating fault
                case (r.kind)
                    OP_DEBUG_A, OP_DEBUG_B: check(64'(orsp.debug_sel), r.ed); // alias target
                    OP_INT_FLAG: check(64'(orsp.virt_int), r.ed); // virtual flags
                    OP_SW_INT: check(64'(orsp.redirect_bitmap), r.ed); // bitmap use
                    default: ;
                endcase
            end
        end
        // reserved numbers fault, state left unchecked; 0 and 8 unclaimed
        for (int n = 0; n < 16; n++) begin
            acc(1'b1, 4'(n), 64'h0);
            if (n == 0 || n == 8)
                check(64'({gc, gf}), 64'({1'b0, FLT_NONE})); // unclaimed
            else if (!(n inside {2, 3, 4}))
                check(64'(gf), 64'(FLT_INVALID_OPCODE)); // reserved number
        end
        // full 64-bit base needs long mode
        @(posedge clk);
        long_mode <= 1'b1;
        acc(1'b1, 4'h3, 64'h0123_4567_89ab_c000);
        check(64'(tlb_flush), 64'h1); // flush on rebase
        @(posedge clk);
        #1;
        check(table_base, 64'h0123_4567_89ab_c000); // walker base
        // page size, widening and global pages
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, 4'h4, pg[k]);
            @(posedge clk);
            #1;
            check(64'(page_cfg), 64'((k == 0) ? 4'h4 : (k == 3) ? 4'h1 : 4'he)); // page config
            check(64'(tlb_keep_global), 64'(k == 3)); // keep global
        end
        // machine check: fault only when enabled and uncorrectable
        acc(1'b1, 4'h4, 64'h40);
        mc(8'h0, 1'b1);
        check(64'(f), 64'h1); // uncorrectable fault
        mc(8'h2, 1'b0);
        check(64'(f), 64'h0); // correctable no fault
        mc(8'h1, 1'b1);
        check(64'({f, mc_status}), 64'h5); // disabled bank ignored
        @(posedge clk);
        mc_status_clr <= 4'hf;
        @(posedge clk);
        mc_status_clr <= 4'h0;
        acc(1'b1, 4'h4, 64'h0);
        mc(8'h0, 1'b1);
        check(64'({f, mc_status}), 64'h1); // recorded without fault
        // reset in mid-run clears the register
        acc(1'b1, 4'h4, 64'h7ff);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1;
        check(ext_ctrl, 64'h0); // cleared by reset
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        acc(1'b0, 4'h4, 64'h0);
        check(got, 64'h0); // reads zero after reset
        finish_test();
    end
endmodule
`default_nettype wire
